//--- core/ocd_divider.sv
// one output divider: single count to upper times lower ratio, bypass and sync hold
`timescale 1ns/100ps
module ocd_divider
    import ocd_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic src_level,
    input wire logic src_rise,
    input wire logic run,
    input wire logic hold_req,
    input wire logic [19:0] div_lo,
    input wire logic [10:0] div_hi,
    output logic clk_div,
    output logic held
);
    typedef struct packed {
        logic [30:0] cnt;
        logic out;
        logic held;
    } ocd_div_state_t;

    ocd_div_state_t st;
    ocd_div_state_t next_st;
    logic [19:0] lo_e;
    logic [10:0] hi_e;
    logic [30:0] ratio;
    logic [30:0] half;
    logic bypass;

    assign lo_e = (div_lo == 20'h0) ? 20'h1 : div_lo;
    assign hi_e = (div_hi == 11'h0) ? 11'h1 : div_hi;
    assign ratio = 31'(lo_e) * 31'(hi_e);
    assign half = 31'((ratio + 31'h1) >> 1);
    assign bypass = (ratio == 31'h1);

    always_comb begin
        next_st = st;
        if (!run) begin
            next_st.cnt = '0;
            next_st.out = 1'b0;
            next_st.held = 1'b1;
        end else if (bypass) begin
            next_st.cnt = '0;
            next_st.out = src_level;
            next_st.held = 1'b0;
        end else if (src_rise) begin
            if (st.held) begin
                if (!hold_req) begin
                    next_st.held = 1'b0;
                    next_st.cnt = '0;
                    next_st.out = 1'b1;
                end
            end else if (st.cnt >= ratio - 31'h1) begin
                next_st.cnt = '0;
                next_st.out = !hold_req;
                next_st.held = hold_req;
            end else begin
                next_st.cnt = st.cnt + 31'h1;
                next_st.out = (st.cnt + 31'h1) < half;
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st <= '{cnt: '0, out: 1'b0, held: 1'b1};
        end else begin
            st <= next_st;
        end
    end

    assign clk_div = st.out;
    assign held = st.held;

    property p_bypass_ignores_sync;
        @(posedge core_clk) disable iff (!nrst)
        (run && bypass && hold_req) |=> (!held && clk_div == $past(src_level));
    endproperty
    a_bypass_ignores_sync: assert property (p_bypass_ignores_sync) else $error("bypass divider gated by sync");

    property p_sync_finishes_cycle;
        @(posedge core_clk) disable iff (!nrst)
        (run && !bypass && !st.held && src_rise && st.cnt == ratio - 31'h1 && hold_req) |=> (held && !clk_div);
    endproperty
    a_sync_finishes_cycle: assert property (p_sync_finishes_cycle) else $error("sync hold not taken at period end");

    property p_period_wraps;
        @(posedge core_clk) disable iff (!nrst)
        (run && !bypass && !st.held && src_rise && st.cnt == ratio - 31'h1 && !hold_req) |=> (clk_div && st.cnt == 31'h0);
    endproperty
    a_period_wraps: assert property (p_period_wraps) else $error("divider period does not restart");
endmodule

//--- core/ocd_output_clock_distribution.sv
// output clock distribution: source muxes, dividers, drivers, squelch and register slave
`timescale 1ns/100ps
// Functional notes
// - channels two to seven pick either synthesizer
// - channels zero, one also offer oscillator, bypass
// - bypass picks oscillator, loop one or two reference
// - pairs two/three and four/five share dividers
// - twenty-bit divide value on channels one to six
// - channels zero, seven: upper times lower divider
// - divider can be powered down by configuration
// - divider sleeps when its drivers all sleep
// - driver type code decodes disabled, differential, hcsl, lvcmos
// - lvcmos pins: true, inverted, high impedance, low
// - auto squelch when selected source is invalid
// - synthesizer validity from gated loop lock losses
// - oscillator sources invalid on loss of signal
// - differential squelch: common mode, high, low
// - lvcmos squelch sets each pin low or high impedance separately
// - enable and level zero bypass auto squelch; sync mute still squelches
// - synthesizer outputs start clean after lock returns
// - clean start after supply, power down, sync
// - unpowered channel makes no clock, disturbs none
// - sync holds enabled dividers after finishing cycle
// - divide-by-one bypass ignores sync
module ocd_output_clock_distribution
    import ocd_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic synth1_pri_clk,
    input wire logic synth1_sec_clk,
    input wire logic synth2_pri_clk,
    input wire logic synth2_sec_clk,
    input wire logic xo_clk,
    input wire logic tcxo_clk,
    input wire logic ref_a_clk,
    input wire logic ref_b_clk,
    input wire logic [1:0] analog_loop_loss_of_lock,
    input wire logic [1:0] ref_loop_loss_of_lock,
    input wire logic [1:0] osc_loop_loss_of_lock,
    input wire logic xo_loss_of_signal,
    input wire logic tcxo_loss_of_signal,
    input wire logic sync_n,
    input wire logic hard_power_down_pin,
    input wire logic [5:0] output_supply_ok,
    output logic [7:0] clock_output_pair_p,
    output logic [7:0] clock_output_pair_n,
    output logic [7:0] clock_output_pair_p_oe_n,
    output logic [7:0] clock_output_pair_n_oe_n
);
    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] power;
        logic [31:0] sel;
        logic [31:0] mute;
        logic [31:0] type_lo;
        logic [31:0] type_hi;
        logic [5:0][31:0] div;
        logic [31:0] divhi;
        logic [7:0] clk_s1;
        logic [7:0] clk_s2;
        logic [7:0] clk_s3;
        logic [15:0] sts_s1;
        logic [15:0] sts_s2;
        logic wait_req;
        logic [31:0] rdata;
        logic [7:0] muted;
        logic [7:0] p;
        logic [7:0] n;
        logic [7:0] p_oe_n;
        logic [7:0] n_oe_n;
    } ocd_state_t;

    ocd_state_t st;
    ocd_state_t next_st;

    // divider serving each output pin pair
    function automatic int out_div(input int i);
        if (i < 2) begin
            return i;
        end else if (i < 6) begin
            return 2 + (i - 2) / 2;
        end else begin
            return i - 2;
        end
    endfunction

    function automatic logic known_type(input logic [7:0] ty);
        logic ok;
        ok = 1'b0;
        case (ty)
            TYPE_AC_LVDS, TYPE_AC_CML, TYPE_AC_LVPECL, TYPE_HCSL_EXT, TYPE_HCSL_INT: ok = 1'b1;
            default: ok = (ty[7:4] == TYPE_LVCMOS_HI);
        endcase
        return ok;
    endfunction

    function automatic logic is_diff(input logic [7:0] ty);
        return ty == TYPE_AC_LVDS || ty == TYPE_AC_CML || ty == TYPE_AC_LVPECL ||
            ty == TYPE_HCSL_EXT || ty == TYPE_HCSL_INT;
    endfunction

    // one lvcmos pin: {oe_n, value}
    function automatic logic [1:0] cmos_pin(input logic [1:0] code, input logic clk, input logic m, input logic low);
        logic [1:0] r;
        r = 2'b10;
        if (m) begin
            r = low ? 2'b00 : 2'b10;
        end else begin
            case (code)
                PIN_LOW: r = 2'b00;
                PIN_INV: r = {1'b0, !clk};
                PIN_TRUE: r = {1'b0, clk};
                default: r = 2'b10;
            endcase
        end
        return r;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be, input logic [31:0] mask);
        logic [31:0] bm;
        bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & mask;
        return (old & ~bm) | (wd & bm);
    endfunction

    logic [7:0] clk_lvl;
    logic [7:0] clk_rise;
    logic [15:0] sts;
    logic soft_reset;
    logic hard_pd;
    logic sync_active;
    logic [1:0] byp_sel;
    logic [2:0] byp_idx;
    logic byp_valid;
    logic [1:0] pll_bad;
    logic [63:0] drv;
    logic [7:0] out_on;
    logic [5:0] div_run;
    logic [5:0] div_clk;
    logic [5:0] div_held;
    logic [5:0] src_valid;

    assign clk_lvl = st.clk_s2;
    assign clk_rise = st.clk_s2 & ~st.clk_s3;
    assign sts = st.sts_s2;
    assign soft_reset = st.ctrl[CTRL_SOFT_RST];
    assign hard_pd = sts[ST_HARD_PD];
    assign sync_active = !sts[ST_SYNC_N] || st.ctrl[CTRL_SYNC_SW];
    assign byp_sel = st.ctrl[CTRL_BYP_SEL +: 2];
    assign byp_idx = (byp_sel == BYP_UNUSED) ? IDX_TCXO : 3'(IDX_TCXO + {1'b0, byp_sel});
    assign byp_valid = (byp_sel == BYP_TCXO || byp_sel == BYP_UNUSED) ? !sts[ST_TCXO_LOS] : 1'b1;
    assign drv = {st.type_hi, st.type_lo};

    generate
        for (genvar k = 0; k < 2; k++) begin : g_pll
            // powered-down or reset synthesizers count as invalid until lock returns
            assign pll_bad[k] = st.ctrl[CTRL_SYNTH_PD + k] || soft_reset || hard_pd ||
                (sts[ST_APLL + k] && st.ctrl[CTRL_SQ_APLL + k]) ||
                (sts[ST_REF + k] && st.ctrl[CTRL_SQ_REF + k]) ||
                (sts[ST_OSC + k] && st.ctrl[CTRL_SQ_OSC + k]);
        end

        for (genvar i = 0; i < 8; i++) begin : g_out
            localparam int D = out_div(i);
            assign out_on[i] = known_type(drv[8 * i +: 8]) && !st.power[PWR_CH_PD + i] &&
                sts[ST_SUPPLY + D] && !hard_pd;
        end

        for (genvar g = 0; g < 6; g++) begin : g_div
            localparam int O1 = (g < 2) ? g : (g < 4) ? 2 * g - 2 : g + 2;
            localparam int O2 = (g == 2 || g == 3) ? O1 + 1 : O1;
            logic [2:0] sel;
            logic [2:0] idx;
            logic [10:0] hi;
            assign sel = (g < 2) ? st.sel[3 * g +: 3] : {1'b0, st.sel[3 * g +: 2]};
            assign idx = (sel < SRC_XO) ? sel : (sel == SRC_XO) ? IDX_XO : byp_idx;
            assign src_valid[g] = (sel < SRC_XO) ? !pll_bad[sel[1]] :
                (sel == SRC_XO) ? !sts[ST_XO_LOS] : byp_valid;
            assign hi = (g == 0) ? st.divhi[10:0] : (g == 5) ? st.divhi[DIVHI_CH7 +: 11] : 11'h1;
            assign div_run[g] = !st.power[PWR_DIV_PD + g] && (out_on[O1] || out_on[O2]) &&
                !soft_reset && sts[ST_SUPPLY + g] && !hard_pd;

            ocd_divider u_div (
                .core_clk(core_clk),
                .nrst(nrst),
                .src_level(clk_lvl[idx]),
                .src_rise(clk_rise[idx]),
                .run(div_run[g]),
                .hold_req(sync_active && st.power[PWR_SYNC_EN + g]),
                .div_lo(st.div[g][19:0]),
                .div_hi(hi),
                .clk_div(div_clk[g]),
                .held(div_held[g])
            );
        end
    endgenerate

    always_comb begin
        int d;
        logic [7:0] ty;
        logic [1:0] lvl;
        logic [1:0] pp;
        logic [1:0] nn;
        logic want;
        logic [31:0] rd;
        d = 0;
        ty = 8'h00;
        lvl = 2'h0;
        pp = 2'h0;
        nn = 2'h0;
        want = 1'b0;
        rd = 32'h0;
        next_st = st;
        next_st.clk_s1 = {ref_b_clk, ref_a_clk, tcxo_clk, xo_clk,
                          synth2_sec_clk, synth2_pri_clk, synth1_sec_clk, synth1_pri_clk};
        next_st.clk_s2 = st.clk_s1;
        next_st.clk_s3 = st.clk_s2;
        next_st.sts_s1 = {output_supply_ok, hard_power_down_pin, sync_n, tcxo_loss_of_signal, xo_loss_of_signal,
                          osc_loop_loss_of_lock, ref_loop_loss_of_lock, analog_loop_loss_of_lock};
        next_st.sts_s2 = st.sts_s1;

        // bus: first cycle latches read data, second cycle completes
        next_st.wait_req = 1'b1;
        if ((avs_read || avs_write) && st.wait_req) begin
            next_st.wait_req = 1'b0;
            case (avs_address)
                OCD_ADDR_CTRL: rd = st.ctrl;
                OCD_ADDR_POWER: rd = st.power;
                OCD_ADDR_SEL: rd = st.sel;
                OCD_ADDR_MUTE: rd = st.mute;
                OCD_ADDR_TYPE_LO: rd = st.type_lo;
                OCD_ADDR_TYPE_HI: rd = st.type_hi;
                OCD_ADDR_DIVHI: rd = st.divhi;
                OCD_ADDR_STATUS: rd = {1'b0, div_held, sync_active, st.muted, 2'h0, src_valid, 2'h0, div_run};
                default: rd = 32'h0;
            endcase
            for (int g = 0; g < 6; g++) begin
                if (avs_address == 8'(OCD_ADDR_DIV0 + 4 * g)) begin
                    rd = st.div[g];
                end
            end
            next_st.rdata = avs_read ? rd : 32'h0;
        end
        if (avs_write && !st.wait_req) begin
            case (avs_address)
                OCD_ADDR_CTRL: next_st.ctrl = merge(st.ctrl, avs_writedata, avs_byteenable, OCD_MASK_CTRL);
                OCD_ADDR_POWER: next_st.power = merge(st.power, avs_writedata, avs_byteenable, OCD_MASK_POWER);
                OCD_ADDR_SEL: next_st.sel = merge(st.sel, avs_writedata, avs_byteenable, OCD_MASK_SEL);
                OCD_ADDR_MUTE: next_st.mute = merge(st.mute, avs_writedata, avs_byteenable, OCD_MASK_MUTE);
                OCD_ADDR_TYPE_LO: next_st.type_lo = merge(st.type_lo, avs_writedata, avs_byteenable, OCD_MASK_TYPE);
                OCD_ADDR_TYPE_HI: next_st.type_hi = merge(st.type_hi, avs_writedata, avs_byteenable, OCD_MASK_TYPE);
                OCD_ADDR_DIVHI: next_st.divhi = merge(st.divhi, avs_writedata, avs_byteenable, OCD_MASK_DIVHI);
                default: next_st.ctrl = st.ctrl;
            endcase
            for (int g = 0; g < 6; g++) begin
                if (avs_address == 8'(OCD_ADDR_DIV0 + 4 * g)) begin
                    next_st.div[g] = merge(st.div[g], avs_writedata, avs_byteenable, OCD_MASK_DIV);
                end
            end
        end

        for (int i = 0; i < 8; i++) begin
            d = out_div(i);
            ty = drv[8 * i +: 8];
            lvl = st.mute[MUTE_LVL + 2 * i +: 2];
            // enable and level both zero never auto squelch; sync mute still can
            want = (st.mute[MUTE_EN + i] && !src_valid[d]) ||
                (st.ctrl[CTRL_SYNC_MUTE] && div_held[d] && st.power[PWR_SYNC_EN + d]);
            if (!div_clk[d]) begin
                next_st.muted[i] = want;
            end
            pp = 2'b10;
            nn = 2'b10;
            if (out_on[i] && div_run[d]) begin
                if (is_diff(ty)) begin
                    if (st.muted[i]) begin
                        pp = {1'b0, lvl == MUTE_HIGH};
                        nn = {1'b0, lvl == MUTE_LOW};
                    end else begin
                        pp = {1'b0, div_clk[d]};
                        nn = {1'b0, !div_clk[d]};
                    end
                end else begin
                    pp = cmos_pin(ty[3:2], div_clk[d], st.muted[i], lvl[0]);
                    nn = cmos_pin(ty[1:0], div_clk[d], st.muted[i], lvl[1]);
                end
            end
            next_st.p_oe_n[i] = pp[1];
            next_st.p[i] = pp[0];
            next_st.n_oe_n[i] = nn[1];
            next_st.n[i] = nn[0];
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
            st.ctrl <= OCD_RST_CTRL;
            st.power <= OCD_RST_POWER;
            st.sel <= OCD_RST_SEL;
            st.mute <= OCD_RST_MUTE;
            st.type_lo <= OCD_RST_TYPE;
            st.type_hi <= OCD_RST_TYPE;
            st.div <= {6{OCD_RST_DIV}};
            st.divhi <= OCD_RST_DIVHI;
            st.sts_s1 <= OCD_RST_STATUS_SYNC;
            st.sts_s2 <= OCD_RST_STATUS_SYNC;
            st.wait_req <= 1'b1;
            st.p_oe_n <= 8'hff;
            st.n_oe_n <= 8'hff;
        end else begin
            st <= next_st;
        end
    end

    assign avs_readdata = st.rdata;
    assign avs_waitrequest = st.wait_req;
    assign clock_output_pair_p = st.p;
    assign clock_output_pair_n = st.n;
    assign clock_output_pair_p_oe_n = st.p_oe_n;
    assign clock_output_pair_n_oe_n = st.n_oe_n;

    generate
        for (genvar i = 0; i < 8; i++) begin : g_chk
            localparam int D = out_div(i);

            property p_unpowered_quiet;
                @(posedge core_clk) disable iff (!nrst)
                !out_on[i] |=> (st.p_oe_n[i] && st.n_oe_n[i] && !st.p[i] && !st.n[i]);
            endproperty
            a_unpowered_quiet: assert property (p_unpowered_quiet) else $error("unpowered output drives");

            property p_squelch_at_low;
                @(posedge core_clk) disable iff (!nrst)
                (st.muted[i] != $past(st.muted[i])) |-> !$past(div_clk[D]);
            endproperty
            a_squelch_at_low: assert property (p_squelch_at_low) else $error("squelch changed in high phase");

            property p_auto_squelch;
                @(posedge core_clk) disable iff (!nrst)
                (st.mute[MUTE_EN + i] && !src_valid[D] && !div_clk[D]) |=> st.muted[i];
            endproperty
            a_auto_squelch: assert property (p_auto_squelch) else $error("invalid source not squelched");

            property p_diff_squelch_high;
                @(posedge core_clk) disable iff (!nrst)
                (out_on[i] && div_run[D] && st.muted[i] && is_diff(drv[8 * i +: 8]) &&
                 st.mute[MUTE_LVL + 2 * i +: 2] == MUTE_HIGH) |=> (st.p[i] && !st.n[i] && !st.p_oe_n[i]);
            endproperty
            a_diff_squelch_high: assert property (p_diff_squelch_high) else $error("wrong high squelch level");

            property p_cmos_static_low;
                @(posedge core_clk) disable iff (!nrst)
                (out_on[i] && div_run[D] && !st.muted[i] && drv[8 * i +: 8] == 8'h35) |=>
                    (!st.p[i] && !st.n[i] && !st.p_oe_n[i] && !st.n_oe_n[i]);
            endproperty
            a_cmos_static_low: assert property (p_cmos_static_low) else $error("lvcmos low pins not low");
        end
    endgenerate
endmodule

//--- core/ocd_pkg.sv
// shared constants for the output clock distribution block
package ocd_pkg;
    // register byte offsets
    localparam logic [7:0] OCD_ADDR_CTRL = 8'h00;
    localparam logic [7:0] OCD_ADDR_POWER = 8'h04;
    localparam logic [7:0] OCD_ADDR_SEL = 8'h08;
    localparam logic [7:0] OCD_ADDR_MUTE = 8'h0c;
    localparam logic [7:0] OCD_ADDR_TYPE_LO = 8'h10;
    localparam logic [7:0] OCD_ADDR_TYPE_HI = 8'h14;
    localparam logic [7:0] OCD_ADDR_DIV0 = 8'h18;
    localparam logic [7:0] OCD_ADDR_DIVHI = 8'h30;
    localparam logic [7:0] OCD_ADDR_STATUS = 8'h34;
    // writable bits per register
    localparam logic [31:0] OCD_MASK_CTRL = 32'h00001fff;
    localparam logic [31:0] OCD_MASK_POWER = 32'h003f3fff;
    localparam logic [31:0] OCD_MASK_SEL = 32'h0003ffff;
    localparam logic [31:0] OCD_MASK_MUTE = 32'h00ffffff;
    localparam logic [31:0] OCD_MASK_TYPE = 32'hffffffff;
    localparam logic [31:0] OCD_MASK_DIV = 32'h000fffff;
    localparam logic [31:0] OCD_MASK_DIVHI = 32'h07ff07ff;
    // reset values
    localparam logic [31:0] OCD_RST_CTRL = 32'h00001f80;
    localparam logic [31:0] OCD_RST_POWER = 32'h00000000;
    localparam logic [31:0] OCD_RST_SEL = 32'h00000000;
    localparam logic [31:0] OCD_RST_MUTE = 32'h000000ff;
    localparam logic [31:0] OCD_RST_TYPE = 32'h00000000;
    localparam logic [31:0] OCD_RST_DIV = 32'h00000004;
    localparam logic [31:0] OCD_RST_DIVHI = 32'h00010001;
    // control register fields
    localparam int CTRL_SOFT_RST = 0;
    localparam int CTRL_SYNC_SW = 1;
    localparam int CTRL_SYNC_MUTE = 2;
    localparam int CTRL_SYNTH_PD = 3;
    localparam int CTRL_BYP_SEL = 5;
    localparam int CTRL_SQ_APLL = 7;
    localparam int CTRL_SQ_REF = 9;
    localparam int CTRL_SQ_OSC = 11;
    // power, mute and upper divider fields
    localparam int PWR_CH_PD = 0;
    localparam int PWR_DIV_PD = 8;
    localparam int PWR_SYNC_EN = 16;
    localparam int MUTE_EN = 0;
    localparam int MUTE_LVL = 8;
    localparam int DIVHI_CH7 = 16;
    // positions in the synchronised status vector
    localparam int ST_APLL = 0;
    localparam int ST_REF = 2;
    localparam int ST_OSC = 4;
    localparam int ST_XO_LOS = 6;
    localparam int ST_TCXO_LOS = 7;
    localparam int ST_SYNC_N = 8;
    localparam int ST_HARD_PD = 9;
    localparam int ST_SUPPLY = 10;
    localparam logic [15:0] OCD_RST_STATUS_SYNC = 16'h0100;
    // source select codes and source clock indexes
    localparam logic [2:0] SRC_XO = 3'h4;
    localparam logic [2:0] IDX_XO = 3'h4;
    localparam logic [2:0] IDX_TCXO = 3'h5;
    localparam logic [1:0] BYP_TCXO = 2'h0;
    localparam logic [1:0] BYP_UNUSED = 2'h3;
    // driver type codes
    localparam logic [7:0] TYPE_OFF = 8'h00;
    localparam logic [7:0] TYPE_AC_LVDS = 8'h10;
    localparam logic [7:0] TYPE_AC_CML = 8'h14;
    localparam logic [7:0] TYPE_AC_LVPECL = 8'h18;
    localparam logic [7:0] TYPE_HCSL_EXT = 8'h2c;
    localparam logic [7:0] TYPE_HCSL_INT = 8'h2d;
    localparam logic [3:0] TYPE_LVCMOS_HI = 4'h3;
    // single pin states in lvcmos mode
    localparam logic [1:0] PIN_HIZ = 2'h0;
    localparam logic [1:0] PIN_LOW = 2'h1;
    localparam logic [1:0] PIN_INV = 2'h2;
    localparam logic [1:0] PIN_TRUE = 2'h3;
    // squelch levels for differential and hcsl drivers
    localparam logic [1:0] MUTE_HIGH = 2'h1;
    localparam logic [1:0] MUTE_LOW = 2'h2;
endpackage

//--- sim/ocd_clk_receiver.sv
// downstream clock receiver model: counts clean rising edges on one driven output pin
`timescale 1ns/100ps
module ocd_clk_receiver (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic pin,
    input wire logic oe_n,
    output logic [15:0] edges
);
    logic last;
    // a released pin carries no clock, so it never counts
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            edges <= 16'h0;
            last <= 1'b0;
        end else begin
            last <= pin & ~oe_n;
            if (pin & ~oe_n & ~last) begin
                edges <= edges + 16'h1;
            end
        end
    end
endmodule

//--- sim/tb_top.sv
// self-checking bench for the output clock distribution block
`timescale 1ns/100ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fail_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
    import ocd_pkg::*;
    logic core_clk = 0;
    logic nrst = 0;
    logic avs_read = 0;
    logic avs_write = 0;
    logic [7:0] avs_address = 0;
    logic [31:0] avs_writedata = 0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata, rd;
    logic [31:0] lf = 32'hf7fa0473;
    logic avs_waitrequest;
    logic [7:0] cnt = 0;
    logic [1:0] alol = 0;
    logic hpd = 0;
    logic sync_n = 1;
    logic [5:0] sup = 6'h3f;
    logic [7:0] p, n, poe, noe;
    logic [15:0] e0;
    int fail_count = 0;
    int samples_checked = 0;
    logic [15:0] m;
    int x;
    int q[$];
    always #20 core_clk = ~core_clk;
    always @(posedge core_clk) cnt <= cnt + 8'h1;
    ocd_output_clock_distribution u_dut (.core_clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .synth1_pri_clk(cnt[2]), .synth1_sec_clk(cnt[3]),
        .synth2_pri_clk(cnt[3]), .synth2_sec_clk(cnt[4]), .xo_clk(cnt[3]), .tcxo_clk(cnt[4]), .ref_a_clk(cnt[3]),
        .ref_b_clk(cnt[4]), .analog_loop_loss_of_lock(alol), .ref_loop_loss_of_lock(2'h0),
        .osc_loop_loss_of_lock(2'h0), .xo_loss_of_signal(1'b0), .tcxo_loss_of_signal(1'b0), .sync_n,
        .hard_power_down_pin(hpd), .output_supply_ok(sup), .clock_output_pair_p(p), .clock_output_pair_n(n),
        .clock_output_pair_p_oe_n(poe), .clock_output_pair_n_oe_n(noe));
    ocd_clk_receiver u_rx (.core_clk, .nrst, .pin(p[1]), .oe_n(poe[1]), .edges(e0));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic report_and_stop;
        if (fail_count == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin @(posedge core_clk); k++; end while (avs_waitrequest !== 1'b0 && k < 50);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (k >= 50) begin fail_count++; report_and_stop(); end
    endtask
    // settle, then count receiver edges over 640 cycles; model: 640 / (source period 8 * ratio)
    task automatic meas(input int ratio);
        logic [15:0] s;
        repeat (64) @(posedge core_clk);
        s = e0;
        repeat (640) @(posedge core_clk);
        m = e0 - s;
        q.push_back(ratio == 0 ? 0 : 640 / (8 * ratio));
        x = q.pop_front();
    endtask
    initial begin
        repeat (12) @(posedge core_clk);
        nrst <= 1'b1;
        bus(0, OCD_ADDR_CTRL, 0); `CHK(rd, OCD_RST_CTRL)
        bus(0, OCD_ADDR_MUTE, 0); `CHK(rd, OCD_RST_MUTE)
        bus(0, OCD_ADDR_DIVHI, 0); `CHK(rd, OCD_RST_DIVHI)
        for (int i = 0; i < 4; i++) begin
            lf = lfsr(lf);
            bus(1, OCD_ADDR_DIV0 + 8'h4, lf);
            bus(0, OCD_ADDR_DIV0 + 8'h4, 0); `CHK(rd, lf & OCD_MASK_DIV)
        end
        bus(1, 8'hfc, lf);
        bus(0, 8'hfc, 0); `CHK(rd, 32'h0)
        bus(1, OCD_ADDR_DIV0 + 8'h4, 32'h4);
        meas(0); `CHK(m, x)
        bus(1, OCD_ADDR_TYPE_LO, {16'h0, TYPE_AC_LVDS, 8'h0});
        meas(4); `CHK(m inside {[x - 1:x + 1]}, 1'b1)
        alol <= 2'h1;
        meas(0); `CHK(m, x)
        alol <= 2'h0;
        meas(4); `CHK(m inside {[x - 1:x + 1]}, 1'b1)
        bus(1, OCD_ADDR_POWER, 32'h2);
        meas(0); `CHK(m, x)
        bus(1, OCD_ADDR_POWER, 32'h200);
        meas(0); `CHK(m, x)
        bus(1, OCD_ADDR_POWER, 32'h0);
        hpd <= 1'b1;
        meas(0); `CHK(m, x)
        hpd <= 1'b0;
        meas(4); `CHK(m inside {[x - 1:x + 1]}, 1'b1)
        // sync holds the enabled divider low; divide-by-one keeps running
        bus(1, OCD_ADDR_POWER, 32'h20000);
        sync_n <= 1'b0;
        meas(0); `CHK(m, x)
        bus(1, OCD_ADDR_DIV0 + 8'h4, 32'h1);
        meas(1); `CHK(m inside {[x - 1:x + 1]}, 1'b1)
        bus(1, OCD_ADDR_DIV0 + 8'h4, 32'h4);
        sync_n <= 1'b1;
        meas(4); `CHK(m inside {[x - 1:x + 1]}, 1'b1)
        bus(1, OCD_ADDR_TYPE_LO, 32'h3a00);
        meas(4); `CHK(m inside {[x - 1:x + 1]}, 1'b1)
        report_and_stop();
    end
endmodule
